// ---- hdl/temp_sensor_i2c_slave_port.sv ----
// Two-wire serial slave front end of a temperature sensor
`timescale 1ns/1ps

// Overview of operation
// - Answer address 10010 plus two strap bits.
// - Shift in address MSB first, then direction.
// - Acknowledge own address, else stay idle.
// - Direction 0 writes, direction 1 reads.
// - Nine clocks per byte, receiver acknowledges.
// - Data changes only with clock low; stop detection.
// - Direction fixed until a new start.
// - First write byte sets pointer, next stores.
// - Limit registers take MSB then LSB byte.
// - Extra written bytes are discarded.
// - One-byte or two-byte reads, MSB first.
// - Read advances only MSB to LSB.
// - Pointer kept between transfers; no block reads.
// - Pointer value 0x2F reloads all defaults.
// - No acknowledges while defaults reload.
// - Acknowledge general call, take next byte.
// - General call 0x06 resets, then busy.
// - Other general call commands get no ack.
// - Limit pairs at 04/05, 06/07, 08/09.
module temp_sensor_i2c_slave_port
#(
  parameter int unsigned RELOAD_LEN = temp_i2c_pkg::RELOAD_CYCLES
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       addr_strap_bit0,
  input  wire logic       addr_strap_bit1,
  output logic      [7:0] reg_addr,
  output logic            reg_wr_en,
  output logic      [7:0] reg_wr_data,
  input  wire logic [7:0] reg_rd_data,
  output logic            reg_rd_en,
  output logic            defaults_reload,
  output logic            reload_busy
);

  import temp_i2c_pkg::*;

  // Synchronised pins and their previous levels
  logic [3:0] pins_q;
  logic       scl_s;
  logic       sda_s;
  logic       strap1;
  logic       strap0;
  logic       scl_d;
  logic       sda_d;

  // Sequencer, shifters, byte position and pointer
  bus_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] rx_shift;
  logic [7:0] tx_shift;
  logic [2:0] byte_idx;
  logic       read_mode;
  logic       gc_mode;
  logic [7:0] ptr;

  // Pins and straps cross into the local clock domain
  bus_sync #(
    .W    (4),
    .INIT (SYNC_INIT)
  ) u_pin_sync (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .d       ({scl_in, sda_in, addr_strap_bit1, addr_strap_bit0}),
    .q       (pins_q)
  );

  assign scl_s  = pins_q[3];
  assign sda_s  = pins_q[2];
  assign strap1 = pins_q[1];
  assign strap0 = pins_q[0];

  // Previous line levels for edge and condition detection
  // Idle-high reset values keep a false edge out after reset
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Line events
  wire scl_rise  = scl_s & ~scl_d;
  wire scl_fall  = ~scl_s & scl_d;
  wire start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_det  = scl_s & scl_d & ~sda_d & sda_s;

  // State decodes
  wire in_recv = (state == ST_RECV);
  wire in_ack  = (state == ST_ACK);
  wire in_send = (state == ST_SEND);
  wire in_mack = (state == ST_MACK);
  wire full    = (bit_cnt == BITS_PER_BYTE);

  // Byte received, decided on the clock fall after the eighth bit
  wire byte_done = in_recv & scl_fall & full;

  // Address compare: fixed bits plus straps, or general call
  wire [6:0] own_addr = {ADDR_FIXED, strap1, strap0};
  wire       addr_hit = (rx_shift[7:1] == own_addr);
  wire       gc_hit   = (rx_shift == {GC_ADDR, DIR_WRITE});
  wire       dir_read = rx_shift[0];

  // Byte position in the transfer
  // Index saturates at the extra-byte slot
  wire at_addr  = (byte_idx == IDX_ADDR);
  wire at_cmd   = (byte_idx == IDX_CMD);
  wire at_data1 = (byte_idx == IDX_DATA1);
  wire at_data2 = (byte_idx == IDX_DATA2);
  wire at_data  = (byte_idx >= IDX_DATA1);

  // Acknowledge decisions, all refused while defaults reload
  wire ack_addr = at_addr & ~reload_busy & (addr_hit | gc_hit);
  wire gc_reset = at_cmd & gc_mode & (rx_shift == GC_RESET_CMD);
  wire ack_gc   = gc_reset & ~reload_busy;
  wire ack_ptr  = at_cmd & ~gc_mode & ~reload_busy;
  wire ack_data = at_data & ~gc_mode & ~reload_busy;
  wire give_ack = byte_done & (ack_addr | ack_gc | ack_ptr | ack_data);

  // Pointer byte and reset command
  wire ptr_load  = byte_done & ack_ptr;
  wire ptr_reset = ptr_load & (rx_shift == PTR_RESET_CMD);
  wire reload_go = ptr_reset | (byte_done & ack_gc);

  // Data writes: first byte to pointer, second to the LSB half
  // Non-pair registers drop the second byte
  wire wr_first  = byte_done & ack_data & at_data1;
  wire wr_second = byte_done & ack_data & at_data2 & is_pair_msb(ptr);
  wire wr_any    = wr_first | wr_second;

  // Read side: load on leaving ack, step MSB to LSB on master ack
  // Master acknowledge is sampled on the clock rise
  wire rd_load    = scl_fall & ((in_ack & read_mode) | in_mack);
  wire mack_seen  = in_mack & scl_rise & ~sda_s;
  wire mack_none  = in_mack & scl_rise & sda_s;
  wire rd_advance = mack_seen & is_pair_msb(reg_addr);
  wire send_next  = in_send & scl_fall & ~full;
  wire send_end   = in_send & scl_fall & full;

  // Sequencer: start always restarts, stop always idles
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
    end else if (start_det) begin
      state <= ST_RECV;
    end else if (stop_det) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          state <= ST_IDLE;
        end
        ST_RECV: begin
          if (byte_done) begin
            state <= give_ack ? ST_ACK : ST_IDLE;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            state <= read_mode ? ST_SEND : ST_RECV;
          end
        end
        ST_SEND: begin
          if (send_end) begin
            state <= ST_MACK;
          end
        end
        ST_MACK: begin
          if (mack_none) begin
            state <= ST_IDLE;
          end else if (scl_fall) begin
            state <= ST_SEND;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Bit counter: counts rising clock edges within a byte
  // The acknowledge pulse is not counted
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt <= BIT_CNT_RESET;
    end else if (start_det | (in_ack & scl_fall) | rd_load) begin
      bit_cnt <= BIT_CNT_RESET;
    end else if ((in_recv | in_send) & scl_rise & ~full) begin
      bit_cnt <= bit_cnt + BIT_STEP;
    end
  end

  // Receive shifter, MSB first
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_shift <= 8'h00;
    end else if (in_recv & scl_rise & ~full) begin
      rx_shift <= {rx_shift[6:0], sda_s};
    end
  end

  // Byte position and transfer modes
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      byte_idx  <= IDX_ADDR;
      read_mode <= 1'b0;
      gc_mode   <= 1'b0;
    end else if (start_det) begin
      byte_idx  <= IDX_ADDR;
      read_mode <= 1'b0;
      gc_mode   <= 1'b0;
    end else if (give_ack) begin
      if (byte_idx != IDX_EXTRA) begin
        byte_idx <= byte_idx + IDX_STEP;
      end
      if (at_addr) begin
        read_mode <= dir_read & ~gc_hit;
        gc_mode   <= gc_hit;
      end
    end
  end

  // Pointer register: written by pointer byte, cleared by reload
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr <= PTR_DEFAULT;
    end else if (reload_go) begin
      ptr <= PTR_DEFAULT;
    end else if (ptr_load) begin
      ptr <= rx_shift;
    end
  end

  // Register address presented to the register bank
  // Read cursor steps; the stored pointer stays put
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_addr <= PTR_DEFAULT;
    end else if (reload_go) begin
      reg_addr <= PTR_DEFAULT;
    end else if (ptr_load) begin
      reg_addr <= rx_shift;
    end else if (byte_done & ack_addr) begin
      reg_addr <= ptr;
    end else if (wr_second | rd_advance) begin
      reg_addr <= ptr + PTR_STEP;
    end
  end

  // Write strobe and data, one cycle per stored data byte
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_wr_en   <= 1'b0;
      reg_wr_data <= 8'h00;
    end else begin
      reg_wr_en <= wr_any;
      if (wr_any) begin
        reg_wr_data <= rx_shift;
      end
    end
  end

  // Read fetch strobe, one cycle per byte sent
  // Start and stop never coincide with a fetch
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rd_en <= 1'b0;
    end else begin
      reg_rd_en <= rd_load & ~start_det & ~stop_det;
    end
  end

  // Transmit shifter: loaded from the bank, MSB first
  // Next bit comes from bit 6 before the shift
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_shift <= 8'h00;
    end else if (rd_load) begin
      tx_shift <= reg_rd_data;
    end else if (send_next) begin
      tx_shift <= {tx_shift[6:0], 1'b0};
    end
  end

  // Data line enable: changes only on a clock fall
  // Start or stop frees the line, so a cut frame ends clean
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sda_oe <= 1'b0;
    end else if (start_det | stop_det) begin
      sda_oe <= 1'b0;
    end else if (byte_done) begin
      sda_oe <= give_ack;
    end else if (rd_load) begin
      sda_oe <= ~reg_rd_data[7];
    end else if (send_next) begin
      sda_oe <= ~tx_shift[6];
    end else if (send_end | (in_ack & scl_fall)) begin
      sda_oe <= 1'b0;
    end
  end

  // Open drain: only a low level is ever driven
  assign sda_out = 1'b0;

  // Defaults reload pulse and refusal window
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      defaults_reload <= 1'b0;
    end else begin
      defaults_reload <= reload_go;
    end
  end

  // Refusal window timer; a new command restarts it
  reload_timer #(
    .CYCLES (RELOAD_LEN)
  ) u_reload_timer (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .start   (reload_go),
    .busy    (reload_busy)
  );

endmodule

// ---- hdl/temp_i2c_pkg.sv ----
// Constants and types shared by the temperature sensor serial slave port
package temp_i2c_pkg;

  // Bus address: fixed upper bits, low two bits from straps
  localparam logic [4:0] ADDR_FIXED     = 5'h12;
  localparam logic [6:0] GC_ADDR        = 7'h00;
  localparam logic       DIR_WRITE      = 1'b0;
  localparam logic [7:0] GC_RESET_CMD   = 8'h06;
  localparam logic [7:0] PTR_RESET_CMD  = 8'h2F;

  // Pointer values of two-byte registers (MSB halves)
  localparam logic [7:0] PTR_TEMP_MSB   = 8'h00;
  localparam logic [7:0] PTR_THIGH_MSB  = 8'h04;
  localparam logic [7:0] PTR_TLOW_MSB   = 8'h06;
  localparam logic [7:0] PTR_TCRIT_MSB  = 8'h08;
  localparam logic [7:0] PTR_DEFAULT    = 8'h00;
  localparam logic [7:0] PTR_STEP       = 8'h01;

  // Bit and byte sequencing
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
  localparam logic [3:0] BIT_CNT_RESET  = 4'h0;
  localparam logic [3:0] BIT_STEP       = 4'h1;
  localparam logic [2:0] IDX_ADDR       = 3'h0;
  localparam logic [2:0] IDX_CMD        = 3'h1;
  localparam logic [2:0] IDX_DATA1      = 3'h2;
  localparam logic [2:0] IDX_DATA2      = 3'h3;
  localparam logic [2:0] IDX_EXTRA      = 3'h4;
  localparam logic [2:0] IDX_STEP       = 3'h1;

  // Idle levels of the two bus lines and straps after reset
  localparam logic [3:0] SYNC_INIT      = 4'hF;

  // Default reload time and its cycle count
  localparam int unsigned RELOAD_TIME_US = 200;
  localparam int unsigned CLK_FREQ_MHZ   = 200;
  localparam int unsigned RELOAD_CYCLES  = RELOAD_TIME_US * CLK_FREQ_MHZ;

  // Bus-side sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RECV = 5'h02,
    ST_ACK  = 5'h04,
    ST_SEND = 5'h08,
    ST_MACK = 5'h10
  } bus_state_t;

  // True for the MSB pointer of a two-byte register
  function automatic logic is_pair_msb(input logic [7:0] p);
    is_pair_msb = (p == PTR_TEMP_MSB) || (p == PTR_THIGH_MSB) ||
                  (p == PTR_TLOW_MSB) || (p == PTR_TCRIT_MSB);
  endfunction

endpackage

// ---- hdl/bus_sync.sv ----
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module bus_sync #(
  parameter int unsigned    W    = 1,
  parameter logic [W-1:0]   INIT = '0
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= INIT;
      q    <= INIT;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// ---- hdl/reload_timer.sv ----
// Busy window while register defaults reload
`timescale 1ns/1ps
module reload_timer #(
  parameter int unsigned CYCLES = 1
) (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic start,
  output logic      busy
);

  logic [31:0] remain;

  // Counts down from the reload length; restart extends it
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      remain <= 32'h0;
      busy   <= 1'b0;
    end else if (start) begin
      remain <= 32'(CYCLES);
      busy   <= 1'b1;
    end else if (remain > 32'h1) begin
      remain <= remain - 32'h1;
    end else begin
      remain <= 32'h0;
      busy   <= 1'b0;
    end
  end

endmodule

// ---- bench/temp_port_checker.sv ----
// Assertions on the ports of the serial slave port
`timescale 1ns/1ps
module temp_port_checker #(
  parameter int unsigned RELOAD_LEN = 50
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic defaults_reload,
  input wire logic reload_busy
);
  int unsigned busy_cnt;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // Length of the current busy window
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= reload_busy ? busy_cnt + 1 : 0;
    end
  end

  // Pin behaviour and reload window
  property p_open_drain;
    sda_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("data pin driven high");
  property p_no_ack_busy;
    $rose(sda_oe) |-> !$past(reload_busy, 30);
  endproperty
  a_no_ack_busy: assert property (p_no_ack_busy) else $error("pin pulled while busy");
  property p_reload_busy;
    defaults_reload |-> ##[0:2] reload_busy;
  endproperty
  a_reload_busy: assert property (p_reload_busy) else $error("reload without busy");
  property p_reload_pulse;
    defaults_reload |=> !defaults_reload;
  endproperty
  a_reload_pulse: assert property (p_reload_pulse) else $error("reload pulse too long");
  property p_busy_len;
    $fell(reload_busy) |-> (busy_cnt + 2 >= RELOAD_LEN) && (busy_cnt <= RELOAD_LEN + 2);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy window length wrong");
  property p_wr_pulse;
    reg_wr_en |-> !reload_busy ##1 !reg_wr_en;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("bad write strobe");
  property p_rd_pulse;
    reg_rd_en |-> !scl_in ##1 !reg_rd_en;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("bad read strobe");
  property p_oe_scl_low;
    !$stable(sda_oe) |-> !scl_in;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("data moved with clock high");
endmodule

bind temp_sensor_i2c_slave_port temp_port_checker #(.RELOAD_LEN(RELOAD_LEN)) i_chk (
  .ref_clk         (ref_clk),
  .rst_b           (rst_b),
  .scl_in          (scl_in),
  .sda_out         (sda_out),
  .sda_oe          (sda_oe),
  .reg_wr_en       (reg_wr_en),
  .reg_rd_en       (reg_rd_en),
  .defaults_reload (defaults_reload),
  .reload_busy     (reload_busy)
);

// ---- bench/bus_master.sv ----
// Behavioural two-wire bus master, open drain on data
`timescale 1ns/1ps
module bus_master (
  output logic      scl,
  output logic      sda_lo,
  input  wire logic sda
);
  // Idle bus: both lines released
  initial begin
    scl = 1'b1;
    sda_lo = 1'b0;
  end

  // One clock pulse: data set while low, sampled while high
  task automatic bit_io(input logic b, output logic r);
    #14 sda_lo = ~b;
    #14 scl = 1'b1;
    #10 r = sda;
    #10 scl = 1'b0;
  endtask

  // Start or repeated start, ends with clock low
  task automatic start_cond();
    #14 sda_lo = 1'b0;
    #14 scl = 1'b1;
    #14 sda_lo = 1'b1;
    #14 scl = 1'b0;
  endtask

  // Stop: data low, clock high, then data released
  task automatic stop_cond();
    #14 sda_lo = 1'b1;
    #14 scl = 1'b1;
    #14 sda_lo = 1'b0;
    #14;
  endtask

  // Eight bits out, then the receiver's acknowledge
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // Eight bits in, then our acknowledge or no-acknowledge
  task automatic rd_byte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(~mack, r);
  endtask
endmodule

// ---- bench/tb.sv ----
// Self-checking bench for the serial slave port
`timescale 1ns/1ps
module tb;
  import temp_i2c_pkg::*;
  localparam int unsigned RLEN = 400;
  localparam int LIMIT = 40000;
  logic        ref_clk, rst_b, scl, m_lo, s0, s1, ack;
  logic        sda_out, sda_oe, reg_wr_en, reg_rd_en, defaults_reload, reload_busy;
  logic  [7:0] reg_addr, reg_wr_data, reg_rd_data, d;
  logic  [6:0] dev;
  wire         sda_w;
  logic [15:0] wlog[$];
  int          mismatches, tests_run, reloads, fetches, cycles, n;

  // Resolved wire and register bank seen by the port
  assign sda_w = (sda_oe ? sda_out : 1'b1) & ~m_lo;
  assign reg_rd_data = reg_addr ^ 8'hA5;

  temp_sensor_i2c_slave_port #(.RELOAD_LEN(RLEN)) i_temp_sensor_i2c_slave_port (
    .ref_clk(ref_clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_strap_bit0(s0), .addr_strap_bit1(s1), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
    .reg_rd_en(reg_rd_en), .defaults_reload(defaults_reload), .reload_busy(reload_busy));

  bus_master mst (.scl(scl), .sda_lo(m_lo), .sda(sda_w));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Write log, reload count and hang limit
  always @(posedge ref_clk) begin
    if (reg_wr_en === 1'b1) wlog.push_back({reg_addr, reg_wr_data});
    if (defaults_reload === 1'b1) reloads++;
    if (reg_rd_en === 1'b1) fetches++;
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic send(input logic [7:0] b, input logic exp_ack);
    mst.wr_byte(b, ack);
    check({15'h0, ack}, {15'h0, exp_ack});
  endtask

  task automatic rd_chk(input logic mack, input logic [7:0] ptr);
    mst.rd_byte(mack, d);
    check({8'h0, d}, {8'h0, ptr ^ 8'hA5});
  endtask

  // Pointer write then read start
  task automatic point(input logic [7:0] p);
    mst.start_cond();
    send({dev, 1'b0}, 1'b1);
    send(p, 1'b1);
    mst.start_cond();
    send({dev, 1'b1}, 1'b1);
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 1000 && reload_busy !== 1'b0; i++) @(negedge ref_clk);
    check({15'h0, reload_busy}, 16'h0);
  endtask

  task automatic t_address();
    for (int s = 0; s < 4; s++) begin
      @(negedge ref_clk);
      {s1, s0} = s[1:0];
      repeat (4) @(negedge ref_clk);
      mst.start_cond();
      send({7'h48 | 7'(s), 1'b0}, 1'b1);
      mst.stop_cond();
      mst.start_cond();
      send({7'h48 | 7'(s ^ 1), 1'b0}, 1'b0);
      mst.stop_cond();
    end
  endtask

  task automatic t_write();
    wlog.delete();
    mst.start_cond();
    send({dev, 1'b0}, 1'b1);
    send(8'h01, 1'b1);
    send(8'h5A, 1'b1);
    send(8'h77, 1'b1);
    mst.stop_cond();
    mst.start_cond();
    send({dev, 1'b0}, 1'b1);
    send(8'h08, 1'b1);
    send(8'h12, 1'b1);
    send(8'h34, 1'b1);
    send(8'h99, 1'b1);
    mst.stop_cond();
    check(16'(wlog.size()), 16'h3);
    check(wlog[0], 16'h015A);
    check(wlog[1], 16'h0812);
    check(wlog[2], 16'h0934);
  endtask

  task automatic t_read();
    n = fetches;
    point(8'h04);
    rd_chk(1'b1, 8'h04);
    rd_chk(1'b0, 8'h05);
    mst.stop_cond();
    mst.start_cond();
    send({dev, 1'b1}, 1'b1);
    rd_chk(1'b1, 8'h04);
    rd_chk(1'b0, 8'h05);
    mst.stop_cond();
    point(8'h03);
    rd_chk(1'b1, 8'h03);
    rd_chk(1'b0, 8'h03);
    mst.stop_cond();
    check(16'(fetches - n), 16'h6);
  endtask

  task automatic t_general();
    mst.start_cond();
    send(8'h00, 1'b1);
    send(8'h05, 1'b0);
    mst.stop_cond();
    mst.start_cond();
    send(8'h01, 1'b0);
    mst.stop_cond();
    n = reloads;
    mst.start_cond();
    send(8'h00, 1'b1);
    send(8'h06, 1'b1);
    mst.stop_cond();
    check(16'(reloads - n), 16'h1);
    mst.start_cond();
    send({dev, 1'b0}, 1'b0);
    mst.stop_cond();
    wait_idle();
  endtask

  task automatic t_ptr_reset();
    n = reloads;
    mst.start_cond();
    send({dev, 1'b0}, 1'b1);
    send(8'h2F, 1'b1);
    mst.stop_cond();
    check(16'(reloads - n), 16'h1);
    mst.start_cond();
    send({dev, 1'b1}, 1'b0);
    mst.stop_cond();
    wait_idle();
    mst.start_cond();
    send({dev, 1'b1}, 1'b1);
    rd_chk(1'b1, 8'h00);
    rd_chk(1'b0, 8'h01);
    mst.stop_cond();
  endtask

  task automatic tally_and_finish();
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Reset, then the scenarios in turn
  initial begin
    rst_b = 1'b0;
    s0 = 1'b0;
    s1 = 1'b0;
    dev = 7'h4B;
    repeat (4) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge ref_clk);
    t_address();
    t_write();
    t_read();
    t_general();
    t_ptr_reset();
    tally_and_finish();
  end
endmodule
